// ===== fpes_seq.sv
// fpes_seq: program/erase sequencer of one code flash erase block, with
// suspend, resume and forced stop timing and write protection.
// assumes commands arrive as one-cycle strobes on the sequencer clock;
// serial path and high-voltage control come from pins.
`timescale 1ns/1ns
module fpes_seq #(
   parameter int PROG_LO_CYC = fpes_pkg::PROG_LO_CYC,
   parameter int PROG_HI_CYC = fpes_pkg::PROG_HI_CYC,
   parameter int ERASE_LO_CYC = fpes_pkg::ERASE_LO_CYC,
   parameter int ERASE_HI_CYC = fpes_pkg::ERASE_HI_CYC,
   parameter int PSUSP_CYC = fpes_pkg::PSUSP_CYC,
   parameter int PRES_CYC = fpes_pkg::PRES_CYC,
   parameter int ESUSP1_CYC = fpes_pkg::ESUSP1_CYC,
   parameter int ERES2_CYC = fpes_pkg::ERES2_CYC,
   parameter int EPRES_CYC = fpes_pkg::EPRES_CYC,
   parameter int PULSE_CYC = fpes_pkg::PULSE_CYC
) (
   // clock and reset
   input wire logic I_CLOCK,
   input wire logic I_RSTN,
   // commands and mode
   input wire fpes_pkg::fpes_cmd_t I_CMD,
   input wire logic I_ERASE_PRIO,
   // pins
   input wire logic I_SERIAL_PATH,
   input wire logic I_HV_SEC_CTL,
   // read check
   input wire logic I_RD_REQ,
   input wire logic [fpes_pkg::UNIT_W-1:0] I_RD_UNIT,
   // results
   output fpes_pkg::fpes_status_t O_STATUS,
   output fpes_pkg::fpes_rd_t O_RD
);

   localparam int TW = fpes_pkg::TMR_W;
   localparam int UN = fpes_pkg::UNITS;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   fpes_pkg::fpes_state_t state_ff;
   fpes_pkg::fpes_state_t nxt_state;
   fpes_pkg::fpes_status_t stat_ff;
   fpes_pkg::fpes_rd_t rd_ff;
   logic ser_s1_ff, ser_s2_ff, hv_s1_ff, hv_s2_ff, hv_prev_ff;
   logic erase_ff, cut_ff, wait_ff, reapply_ff;
   logic [fpes_pkg::UNIT_W-1:0] unit_ff;
   // one bit per unit; more state than a register bank warrants
   logic prog_map_ff [UN];
   logic undef_map_ff [UN];
   logic [TW-1:0] wait_cnt_ff;
   logic op_done, pulse_done, lat_done;

   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   fpes_pkg::fpes_cmd_t c;
   assign c = I_CMD;
   wire st_idle = (state_ff == fpes_pkg::S_IDLE);
   wire st_run = (state_ff == fpes_pkg::S_RUN);
   wire st_stop = (state_ff == fpes_pkg::S_STOP);
   wire st_susp = (state_ff == fpes_pkg::S_SUSP);
   wire st_res = (state_ff == fpes_pkg::S_RES);
   wire st_fstop = (state_ff == fpes_pkg::S_FSTOP);
   wire is_p = c.valid && c.code == fpes_pkg::C_PROG;
   wire is_e = c.valid && c.code == fpes_pkg::C_ERASE;
   wire is_s = c.valid && c.code == fpes_pkg::C_SUSP;
   wire is_r = c.valid && c.code == fpes_pkg::C_RES;
   wire is_f = c.valid && c.code == fpes_pkg::C_FSTOP;
   wire worn = (c.wear >= fpes_pkg::WEAR_LIMIT);
   wire prot_hit = c.boot && !ser_s2_ff;
   wire ovw_hit = prog_map_ff[c.unit];
   wire try_pe = (is_p || is_e) && st_idle;
   wire acc_p = is_p && st_idle && !prot_hit && !ovw_hit;
   wire acc_e = is_e && st_idle && !prot_hit;
   // suspend meeting the end of work is refused, work completes
   wire acc_s = is_s && st_run && !op_done;
   wire acc_r = is_r && st_susp;
   wire acc_f = is_f && !st_idle && !st_fstop;
   wire acc_any = acc_p || acc_e || acc_s || acc_r || acc_f;
   // second suspend or erasure priority waits for pulse end
   wire susp_wait = erase_ff && (I_ERASE_PRIO || cut_ff);
   wire hv_fall = hv_prev_ff && !hv_s2_ff;

   // ------------------------------------------------------------
   // timer control
   // ------------------------------------------------------------
   // program time by wear
   wire [TW-1:0] prog_val = worn ? TW'(PROG_HI_CYC) : TW'(PROG_LO_CYC);
   wire [TW-1:0] erase_val = worn ? TW'(ERASE_HI_CYC) : TW'(ERASE_LO_CYC);
   wire op_load = acc_p || acc_e;
   wire [TW-1:0] op_val = is_e ? erase_val : prog_val;
   wire pulsing = erase_ff && (st_run || (st_stop && wait_ff));
   wire op_run = st_run || (st_stop && wait_ff);
   wire res_exit = st_res && lat_done;
   // reapply a full pulse after a cut
   wire pulse_load = acc_e || (pulsing && pulse_done) ||
                     (res_exit && reapply_ff);
   wire [TW-1:0] susp_val = erase_ff ? TW'(ESUSP1_CYC) : TW'(PSUSP_CYC);
   wire [TW-1:0] res_val = !erase_ff ? TW'(PRES_CYC) :
                           I_ERASE_PRIO ? TW'(EPRES_CYC) : TW'(ERES2_CYC);
   wire [TW-1:0] lat_val = acc_f ? TW'(fpes_pkg::FSTOP_CYC) :
                           acc_r ? res_val : susp_val;
   wire lat_load = (acc_s && !susp_wait) || acc_r || acc_f;
   wire lat_run = (st_stop && !wait_ff) || st_res || st_fstop;
   wire op_end = op_run && op_done;
   wire pulse_end = pulsing && pulse_done;

   fpes_timer #(.WIDTH(TW)) u_op (
      .i_clock(I_CLOCK),
      .i_rstn(I_RSTN),
      .i_load(op_load),
      .i_value(op_val),
      .i_run(op_run),
      .o_done(op_done)
   );

   fpes_timer #(.WIDTH(TW)) u_pulse (
      .i_clock(I_CLOCK),
      .i_rstn(I_RSTN),
      .i_load(pulse_load),
      .i_value(TW'(PULSE_CYC)),
      .i_run(pulsing),
      .o_done(pulse_done)
   );

   fpes_timer #(.WIDTH(TW)) u_lat (
      .i_clock(I_CLOCK),
      .i_rstn(I_RSTN),
      .i_load(lat_load),
      .i_value(lat_val),
      .i_run(lat_run),
      .o_done(lat_done)
   );

   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         fpes_pkg::S_IDLE:
            if (acc_p || acc_e)
               nxt_state = fpes_pkg::S_RUN;
         fpes_pkg::S_RUN:
            if (acc_f)
               nxt_state = fpes_pkg::S_FSTOP;
            else if (op_end)
               nxt_state = fpes_pkg::S_IDLE;
            else if (acc_s)
               nxt_state = fpes_pkg::S_STOP;
         fpes_pkg::S_STOP:
            if (acc_f)
               nxt_state = fpes_pkg::S_FSTOP;
            else if (wait_ff && op_end)
               nxt_state = fpes_pkg::S_IDLE;
            else if (wait_ff ? pulse_end : lat_done)
               nxt_state = fpes_pkg::S_SUSP;
         fpes_pkg::S_SUSP:
            if (acc_f)
               nxt_state = fpes_pkg::S_FSTOP;
            else if (acc_r)
               nxt_state = fpes_pkg::S_RES;
         fpes_pkg::S_RES:
            if (acc_f)
               nxt_state = fpes_pkg::S_FSTOP;
            else if (lat_done)
               nxt_state = fpes_pkg::S_RUN;
         fpes_pkg::S_FSTOP:
            if (lat_done)
               nxt_state = fpes_pkg::S_IDLE;
         default:
            nxt_state = fpes_pkg::S_IDLE;
      endcase
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RSTN)
      begin
         state_ff <= fpes_pkg::S_IDLE;
         erase_ff <= 1'b0;
         cut_ff <= 1'b0;
         wait_ff <= 1'b0;
         reapply_ff <= 1'b0;
         unit_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
         if (op_load)
         begin
            erase_ff <= is_e;
            unit_ff <= c.unit;
         end
         if (acc_s)
            wait_ff <= susp_wait;
         // pulse end forgets cuts; a new cut marks the pulse
         if (op_load || pulse_end)
            cut_ff <= 1'b0;
         else if (acc_s && erase_ff && !susp_wait)
            cut_ff <= 1'b1;
         if (acc_s)
            reapply_ff <= erase_ff && !susp_wait;
      end
   end

   // ------------------------------------------------------------
   // unit state maps
   // ------------------------------------------------------------
   wire fin = st_fstop && lat_done;
   always_ff @(posedge I_CLOCK)
   begin
      for (int i = 0; i < UN; i++)
      begin
         if (!I_RSTN)
         begin
            prog_map_ff[i] <= 1'b0;
            undef_map_ff[i] <= 1'b0;
         end
         // erase clears the block for new data
         else if (op_end && erase_ff)
         begin
            prog_map_ff[i] <= 1'b0;
            undef_map_ff[i] <= 1'b0;
         end
         // stopped erase leaves the whole block undefined
         else if (fin && erase_ff)
            undef_map_ff[i] <= 1'b1;
         else if (i == int'(unit_ff) && !erase_ff && (op_end || fin))
         begin
            prog_map_ff[i] <= 1'b1;
            undef_map_ff[i] <= fin;
         end
      end
   end

   // ------------------------------------------------------------
   // pins, status and read check
   // ------------------------------------------------------------
   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RSTN)
      begin
         {ser_s1_ff, ser_s2_ff} <= 2'h0;
         {hv_s1_ff, hv_s2_ff, hv_prev_ff} <= 3'h0;
      end
      else
      begin
         {ser_s1_ff, ser_s2_ff} <= {I_SERIAL_PATH, ser_s1_ff};
         {hv_s1_ff, hv_s2_ff, hv_prev_ff} <= {I_HV_SEC_CTL, hv_s1_ff, hv_s2_ff};
      end
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RSTN)
      begin
         stat_ff <= '{ready: 1'b1, default: 1'b0};
         rd_ff <= '0;
         wait_cnt_ff <= '0;
      end
      else
      begin
         stat_ff.ready <= (nxt_state == fpes_pkg::S_IDLE) ||
                          (nxt_state == fpes_pkg::S_SUSP);
         stat_ff.suspended <= (nxt_state == fpes_pkg::S_SUSP);
         // fall while busy sets the error; set wins
         stat_ff.hve_err <= (hv_fall && !stat_ff.ready) ||
                            (stat_ff.hve_err && !op_load);
         stat_ff.prot_err <= try_pe && prot_hit;
         stat_ff.ovw_err <= is_p && st_idle && !prot_hit && ovw_hit;
         stat_ff.cmd_rej <= c.valid && !acc_any;
         // blank unit reads as ECC and parity error
         rd_ff.ecc_err <= I_RD_REQ && !prog_map_ff[I_RD_UNIT];
         rd_ff.par_err <= I_RD_REQ && !prog_map_ff[I_RD_UNIT];
         rd_ff.undef <= I_RD_REQ && undef_map_ff[I_RD_UNIT];
         // cycles since the last accepted command
         if (acc_any)
            wait_cnt_ff <= '0;
         else if (!(&wait_cnt_ff))
            wait_cnt_ff <= wait_cnt_ff + 1'b1;
      end
   end

   assign O_STATUS = stat_ff;
   assign O_RD = rd_ff;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_RSTN);

   sequence s_prog_done;
      st_run && !erase_ff && op_done && !acc_f;
   endsequence

   ready_drop_a: assert property (acc_any |=> !O_STATUS.ready)
      else $error("ready held after accepted command");
   boot_refuse_a: assert property (
      try_pe && prot_hit |=> O_STATUS.prot_err && st_idle)
      else $error("boot area write not refused");
   no_overwrite_a: assert property (
      acc_p |-> !prog_map_ff[c.unit])
      else $error("programmed unit accepted again");
   psusp_lat_a: assert property (
      st_stop && !erase_ff |-> wait_cnt_ff <= TW'(PSUSP_CYC))
      else $error("program suspend too slow");
   cut_lat_a: assert property (
      st_stop && erase_ff && !wait_ff |-> wait_cnt_ff <= TW'(ESUSP1_CYC))
      else $error("first erase suspend too slow");
   pulse_wait_a: assert property (
      st_stop && wait_ff |-> wait_cnt_ff <= TW'(PULSE_CYC))
      else $error("pulse end suspend too slow");
   resume_lat_a: assert property (
      st_res |-> wait_cnt_ff <= TW'(!erase_ff ? PRES_CYC :
                                 I_ERASE_PRIO ? EPRES_CYC : ERES2_CYC))
      else $error("resume overhead too long");
   fstop_lat_a: assert property (
      st_fstop |-> wait_cnt_ff <= TW'(fpes_pkg::FSTOP_CYC))
      else $error("forced stop too slow");
   hve_flag_a: assert property (
      hv_fall && !O_STATUS.ready |=> O_STATUS.hve_err)
      else $error("high-voltage error not flagged");
   prog_mark_a: assert property (
      s_prog_done |=> prog_map_ff[unit_ff] ##0 O_STATUS.ready)
      else $error("program end not recorded");
   blank_read_a: assert property (
      I_RD_REQ && !prog_map_ff[I_RD_UNIT] |=> O_RD.ecc_err && O_RD.par_err)
      else $error("blank read not reported");

endmodule : fpes_seq

// ===== fpes_pkg.sv
// fpes_pkg: constants, timing figures and carrier types of the flash
// program/erase sequencer.
// assumes a 125 MHz sequencer clock; all counts derive from CLK_NS.
package fpes_pkg;

   // ------------------------------------------------------------
   // clock and array geometry
   // ------------------------------------------------------------
   localparam int CLK_NS = 8;
   localparam int UNIT_BYTES = 512;
   localparam int BLOCK_BYTES = 65536;
   localparam int UNITS = BLOCK_BYTES / UNIT_BYTES;
   localparam int UNIT_W = $clog2(UNITS);
   localparam int WEAR_W = 16;
   localparam logic [WEAR_W-1:0] WEAR_LIMIT = 16'h0064;
   localparam int TMR_W = 26;

   // ------------------------------------------------------------
   // longest times in ns; counts round down
   // ------------------------------------------------------------
   localparam int PROG_LO_NS = 1700000;
   localparam int PROG_HI_NS = 2100000;
   localparam int ERASE_LO_NS = 330000000;
   localparam int ERASE_HI_NS = 396000000;
   localparam int PSUSP_NS = 120000;
   localparam int PRES_NS = 50000;
   localparam int ESUSP1_NS = 120000;
   localparam int ERES1_NS = 1700000;
   localparam int ERES2_NS = 80000;
   localparam int EPRES_NS = 80000;
   localparam int FSTOP_NS = 20000;

   localparam int PROG_LO_CYC = PROG_LO_NS / CLK_NS;
   localparam int PROG_HI_CYC = PROG_HI_NS / CLK_NS;
   localparam int ERASE_LO_CYC = ERASE_LO_NS / CLK_NS;
   localparam int ERASE_HI_CYC = ERASE_HI_NS / CLK_NS;
   localparam int PSUSP_CYC = PSUSP_NS / CLK_NS;
   localparam int PRES_CYC = PRES_NS / CLK_NS;
   localparam int ESUSP1_CYC = ESUSP1_NS / CLK_NS;
   localparam int ERES1_CYC = ERES1_NS / CLK_NS;
   localparam int ERES2_CYC = ERES2_NS / CLK_NS;
   localparam int EPRES_CYC = EPRES_NS / CLK_NS;
   localparam int FSTOP_CYC = FSTOP_NS / CLK_NS;
   // reapplied pulse plus overhead must fit the first-resume bound
   localparam int PULSE_CYC = ERES1_CYC - ERES2_CYC;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0]
   {
      C_NONE = 3'h0,
      C_PROG = 3'h1,
      C_ERASE = 3'h2,
      C_SUSP = 3'h3,
      C_RES = 3'h4,
      C_FSTOP = 3'h5
   } fpes_code_t;

   typedef enum logic [5:0]
   {
      S_IDLE = 6'h01,
      S_RUN = 6'h02,
      S_STOP = 6'h04,
      S_SUSP = 6'h08,
      S_RES = 6'h10,
      S_FSTOP = 6'h20
   } fpes_state_t;

   typedef struct packed
   {
      logic valid;
      fpes_code_t code;
      logic [UNIT_W-1:0] unit;
      logic boot;
      logic [WEAR_W-1:0] wear;
   } fpes_cmd_t;

   typedef struct packed
   {
      logic ready;
      logic suspended;
      logic hve_err;
      logic prot_err;
      logic ovw_err;
      logic cmd_rej;
   } fpes_status_t;

   typedef struct packed
   {
      logic ecc_err;
      logic par_err;
      logic undef;
   } fpes_rd_t;

endpackage : fpes_pkg

// ===== fpes_timer.sv
// fpes_timer: loadable down counter used for pulse, work and latency.
// assumes load and run come from logic on the same clock.
`timescale 1ns/1ns
module fpes_timer #(
   parameter int WIDTH = 26
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rstn,
   // control
   input wire logic i_load,
   input wire logic [WIDTH-1:0] i_value,
   input wire logic i_run,
   // state
   output logic o_done
);

   logic [WIDTH-1:0] count_ff;
   logic [WIDTH-1:0] nxt_count;
   wire zero = (count_ff == '0);

   // load beats run; counter parks at zero
   assign nxt_count = i_load ? i_value :
                      (i_run && !zero) ? count_ff - 1'b1 : count_ff;
   assign o_done = zero;

   always_ff @(posedge i_clock)
   begin
      if (!i_rstn)
         count_ff <= '0;
      else
         count_ff <= nxt_count;
   end

endmodule : fpes_timer

// ===== fpes_host.sv
// fpes_host: command source standing in for host software.
// assumes commands and pin changes are launched on rising clock edges.
`timescale 1ns/1ns
module fpes_host (
   // clock
   input wire logic i_clock,
   // toward the sequencer
   output fpes_pkg::fpes_cmd_t o_cmd,
   output logic o_hv_sec_ctl
);
   // ------------------------------------------------------------
   // command and pin drivers
   // ------------------------------------------------------------
   initial
   begin
      o_cmd = '0;
      o_hv_sec_ctl = 1'b1;
   end

   task issue(input fpes_pkg::fpes_code_t c,
      input logic [fpes_pkg::UNIT_W-1:0] u, input logic b,
      input logic [fpes_pkg::WEAR_W-1:0] w);
      fpes_pkg::fpes_cmd_t k;
      k = {1'b1, c, u, b, w};
      @(posedge i_clock);
      o_cmd <= k;
      @(posedge i_clock);
      // idle fields inverted so stale values never look valid
      k = ~k;
      k.valid = 1'b0;
      o_cmd <= k;
   endtask : issue

   task hv_set(input logic v);
      @(posedge i_clock);
      o_hv_sec_ctl <= v;
   endtask : hv_set
endmodule : fpes_host

// ===== tb_top.sv
// tb_top: self-checking bench of the flash sequencer with a host model.
// assumes shortened cycle counts; forced stop keeps the package count.
`timescale 1ns/1ns
module tb_top;
   localparam int PLO = 40;
   localparam int PHI = 50;
   localparam int ELO = 400;
   localparam int EHI = 480;
   localparam int PSU = 10;
   localparam int PRE = 6;
   localparam int ESU = 10;
   localparam int ER2 = 8;
   localparam int EPR = 8;
   localparam int PUL = 30;
   localparam int FST = fpes_pkg::FSTOP_CYC;
   logic clock;
   logic rstn;
   logic prio;
   logic serial;
   logic rd_req;
   logic [fpes_pkg::UNIT_W-1:0] rd_unit;
   logic clr;
   logic [5:0] seen;
   logic hv;
   fpes_pkg::fpes_cmd_t cmd;
   fpes_pkg::fpes_status_t st;
   fpes_pkg::fpes_rd_t rd;
   int n_fail;
   int n_checks;
   int seed;
   int n;
   int u;
   int w;
   bit undf;
   bit prog [128];

   fpes_host host (.i_clock(clock), .o_cmd(cmd), .o_hv_sec_ctl(hv));
   fpes_seq #(.PROG_LO_CYC(PLO), .PROG_HI_CYC(PHI), .ERASE_LO_CYC(ELO),
      .ERASE_HI_CYC(EHI), .PSUSP_CYC(PSU), .PRES_CYC(PRE),
      .ESUSP1_CYC(ESU), .ERES2_CYC(ER2), .EPRES_CYC(EPR),
      .PULSE_CYC(PUL)) uut (.I_CLOCK(clock), .I_RSTN(rstn), .I_CMD(cmd),
      .I_ERASE_PRIO(prio), .I_SERIAL_PATH(serial), .I_HV_SEC_CTL(hv),
      .I_RD_REQ(rd_req), .I_RD_UNIT(rd_unit), .O_STATUS(st), .O_RD(rd));

   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // pulses are short; collect them so a check never misses one
   always @(posedge clock)
   begin
      if (clr)
         seen <= 6'h00;
      else
         seen <= seen | {st.prot_err, st.ovw_err, st.cmd_rej, rd};
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task chk(input logic [5:0] got, input logic [5:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task rng(input int v, input int lo, input int hi);
      n_checks++;
      if (v < lo || v > hi)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h to %h", $time,
            v, lo, hi);
      end
   endtask : rng

   task go(input fpes_pkg::fpes_code_t c, input int un, input logic b,
      input int wr);
      clr <= 1'b1;
      @(posedge clock);
      clr <= 1'b0;
      host.issue(c, un[6:0], b, wr[15:0]);
   endtask : go

   task wrdy(output int k);
      k = 0;
      do
      begin
         @(posedge clock);
         #1;
         k++;
      end
      while (st.ready !== 1'b1 && k < 6000);
   endtask : wrdy

   task fl(input logic [5:0] e);
      repeat (3) @(posedge clock);
      #1;
      chk(seen, e);
   endtask : fl

   task rdc(input int un);
      @(posedge clock);
      clr <= 1'b1;
      rd_req <= 1'b1;
      rd_unit <= un[6:0];
      @(posedge clock);
      clr <= 1'b0;
      rd_req <= 1'b0;
      rd_unit <= ~un[6:0];
      fl({3'h0, ~prog[un], ~prog[un], undf});
   endtask : rdc

   task pgm(input int un, input int wr);
      int lim;
      lim = (wr >= 100 ? PHI : PLO) + 1;
      if (prog[un])
      begin
         go(fpes_pkg::C_PROG, un, 1'b0, wr);
         fl(6'h18);
      end
      else
      begin
         go(fpes_pkg::C_PROG, un, 1'b0, wr);
         wrdy(n);
         rng(n, lim, lim + 2);
         prog[un] = 1'b1;
      end
   endtask : pgm

   task conclude;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial
   begin
      repeat (20000) @(posedge clock);
      n_fail++;
      conclude();
   end

   initial
   begin
      n_fail = 0;
      n_checks = 0;
      seed = 87;
      undf = 1'b0;
      rstn = 1'b0;
      prio = 1'b0;
      serial = 1'b0;
      rd_req = 1'b0;
      rd_unit = 7'h00;
      clr = 1'b1;
      seen = 6'h00;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      repeat (3) @(posedge clock);
      #1;
      chk(st, 6'h20);
      go(fpes_pkg::C_RES, 0, 1'b0, 0);
      fl(6'h08);
      rdc(5);
      pgm(5, 0);
      rdc(5);
      pgm(5, 0);
      pgm(6, 100);
      repeat (4)
      begin
         u = 16 + ($unsigned($random(seed)) % 48);
         w = $unsigned($random(seed)) % 200;
         pgm(u, w);
         rdc(u);
      end
      // program suspended, resume refused a second suspend in overhead
      go(fpes_pkg::C_PROG, 7, 1'b0, 0);
      prog[7] = 1'b1;
      repeat (10) @(posedge clock);
      go(fpes_pkg::C_SUSP, 0, 1'b0, 0);
      wrdy(n);
      rng(n, PSU + 1, PSU + 3);
      chk({5'h00, st.suspended}, 6'h01);
      go(fpes_pkg::C_RES, 0, 1'b0, 0);
      go(fpes_pkg::C_SUSP, 0, 1'b0, 0);
      fl(6'h08);
      wrdy(n);
      rng(n, 1, PLO + PRE - 8);
      // enable dropped while busy
      go(fpes_pkg::C_PROG, 9, 1'b0, 0);
      prog[9] = 1'b1;
      host.hv_set(1'b0);
      repeat (6) @(posedge clock);
      #1;
      chk({5'h00, st.hve_err}, 6'h01);
      host.hv_set(1'b1);
      wrdy(n);
      rng(n, 1, PLO + 2);
      // suspension priority: cut, reapplied pulse, second suspend
      go(fpes_pkg::C_ERASE, 0, 1'b0, 0);
      repeat (5) @(posedge clock);
      go(fpes_pkg::C_SUSP, 0, 1'b0, 0);
      wrdy(n);
      rng(n, ESU + 1, ESU + 3);
      go(fpes_pkg::C_RES, 0, 1'b0, 0);
      repeat (ER2 + 6) @(posedge clock);
      go(fpes_pkg::C_SUSP, 0, 1'b0, 0);
      wrdy(n);
      rng(n, PUL - 12, PUL + 3);
      go(fpes_pkg::C_RES, 0, 1'b0, 0);
      wrdy(n);
      rng(n, ER2, ELO + PUL + ER2 + 4);
      foreach (prog[i]) prog[i] = 1'b0;
      rdc(5);
      pgm(5, 0);
      // erasure priority, then forced stop while suspended
      @(posedge clock);
      prio <= 1'b1;
      go(fpes_pkg::C_ERASE, 0, 1'b0, 0);
      repeat (5) @(posedge clock);
      go(fpes_pkg::C_SUSP, 0, 1'b0, 0);
      wrdy(n);
      rng(n, ESU + 4, PUL + 3);
      chk({5'h00, st.suspended}, 6'h01);
      go(fpes_pkg::C_FSTOP, 0, 1'b0, 0);
      wrdy(n);
      rng(n, FST + 1, FST + 3);
      undf = 1'b1;
      rdc(5);
      go(fpes_pkg::C_ERASE, 0, 1'b0, 100);
      wrdy(n);
      rng(n, EHI + 1, EHI + 3);
      foreach (prog[i]) prog[i] = 1'b0;
      undf = 1'b0;
      rdc(5);
      // boot area only through the serial path
      go(fpes_pkg::C_PROG, 100, 1'b1, 0);
      fl(6'h28);
      @(posedge clock);
      serial <= 1'b1;
      repeat (4) @(posedge clock);
      go(fpes_pkg::C_PROG, 100, 1'b1, 0);
      wrdy(n);
      rng(n, PLO + 1, PLO + 3);
      // forced stop of a running program leaves the unit undefined
      go(fpes_pkg::C_PROG, 11, 1'b0, 0);
      repeat (5) @(posedge clock);
      go(fpes_pkg::C_FSTOP, 0, 1'b0, 0);
      wrdy(n);
      rng(n, FST + 1, FST + 3);
      prog[11] = 1'b1;
      undf = 1'b1;
      rdc(11);
      conclude();
   end
endmodule : tb_top
